// file: rtl/madec_defs.svh
// memory address decoder constants: offsets, bounds, reset values
// assumes inclusion by bare name from design files
`ifndef MADEC_DEFS_SVH
`define MADEC_DEFS_SVH

`define MADEC_RF_SIZE        13'h1000
`define MADEC_CTRL_BASE      12'hF00
`define MADEC_CTRL_TOP       12'hFFF
`define MADEC_RAM_BASE       12'h000
`define MADEC_PM_SIZE        17'h10000
`define MADEC_UNIMPL_BYTE    8'hFF
`define MADEC_OPT_LO         16'h0000
`define MADEC_RESET_VEC      16'h0002
`define MADEC_WDT_VEC        16'h0004
`define MADEC_ILL_VEC        16'h0006
`define MADEC_IRQ_VEC_LO     16'h0008
`define MADEC_IRQ_VEC_HI     16'h0037
`define MADEC_RSV_VEC        16'h0038
`define MADEC_OSC_VEC_LO     16'h003A
`define MADEC_OSC_VEC_HI     16'h003D
`define MADEC_CODE_BASE      16'h003E
`define MADEC_INFO_LO        16'hFE00
`define MADEC_INFO_HI        16'hFF7F
`define MADEC_PARTNO_LO      7'h40
`define MADEC_PARTNO_HI      7'h53
`define MADEC_INFO_EN_BIT    7
`define MADEC_INFO_DEPTH     128
`define MADEC_RDATA_RST      8'h00

`endif

// file: rtl/madec_pkg.sv
// memory address decoder types
// assumes madec_defs.svh is compiled alongside
package madec_pkg;

  typedef enum logic [2:0] {
    MADEC_RF_RAM,
    MADEC_RF_HOLE,
    MADEC_RF_CTRL
  } madec_rf_tgt_t;

  typedef enum logic [3:0] {
    MADEC_PM_OPTION,
    MADEC_PM_RESET_VEC,
    MADEC_PM_WDT_VEC,
    MADEC_PM_ILL_VEC,
    MADEC_PM_IRQ_VEC,
    MADEC_PM_RSV_VEC,
    MADEC_PM_OSC_VEC,
    MADEC_PM_CODE,
    MADEC_PM_UNIMPL,
    MADEC_PM_INFO
  } madec_pm_tgt_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } madec_rf_req_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } madec_pm_req_t;

endpackage

// file: rtl/madec_info_rom.sv
// read-only information area, 128 bytes, part number at 0x40..0x53
// assumes the part string is given as a parameter, left-justified
`include "madec_defs.svh"

module madec_info_rom #(
  parameter int         PARTNO_LEN = 20,
  parameter logic [159:0] PARTNO   = {"ANYPART", {13{8'hFF}}},
  parameter logic [7:0] CAL_FILL   = 8'hFF
) (
  input  wire logic       clk,
  input  wire logic [6:0] addr,
  output logic      [7:0] rdata
);

  // =====================================================================
  // constant contents, no write path exists
  logic [7:0] rom [`MADEC_INFO_DEPTH];

  generate
    for (genvar i = 0; i < `MADEC_INFO_DEPTH; i++)
    begin : g_rom
      if (i >= `MADEC_PARTNO_LO && i <= `MADEC_PARTNO_HI)
      begin : g_pn
        assign rom[i] = PARTNO[159 - 8*(i - `MADEC_PARTNO_LO) -: 8]; // RL16
      end
      else
      begin : g_cal
        assign rom[i] = CAL_FILL;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    rdata <= rom[addr]; // RL15
  end

endmodule

// file: rtl/madec_top.sv
// memory address decoder: register file, program memory, info overlay
// assumes core issues one access per cycle; read data three cycles later
//
// Behaviour
// [RL1] Register file space of 4096 bytes is decoded into RAM and control sections.
// [RL2] Addresses F00H to FFFH are routed to the control register section.
// [RL3] Reserved control addresses read undefined; software should not write them.
// [RL4] On-chip RAM starts at register file address 000H and is contiguous.
// [RL5] RAM size is a parameter from 256 bytes to 1 KB fixing the RAM end.
// [RL6] Addresses between RAM end and the control region read undefined, writes ignored.
// [RL7] Program memory is a separate 64 KB space.
// [RL8] Flash is a parameter from 1 KB to 8 KB starting at program address zero.
// [RL9] Program reads above flash return FFH and writes there do nothing.
// [RL10] Low program addresses decode to option bits, vectors, reserved pair, osc traps.
// [RL11] Code region begins at 003E and ends at the top of flash.
// [RL12] No data memory space is implemented.
// [RL13] Info area access is enabled only while bit 7 of page select is 1.
// [RL14] With info enabled, reads of FE00H..FF7FH return info-area bytes.
// [RL15] The info area is read-only through every path.
// [RL16] Info offsets 40H..53H hold a 20-character part number padded with FFH.
// [RL17] With info disabled, FE00H..FF7FH decode as normal program memory.
`include "madec_defs.svh"

module madec_top #(
  parameter int RAM_BYTES   = 1024,
  parameter int FLASH_BYTES = 8192
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire madec_pkg::madec_rf_req_t      rf_req,
  input  wire logic                    [7:0] ram_rdata,
  input  wire logic                    [7:0] ctrl_rdata,
  input  wire logic                    [7:0] page_sel,
  input  wire madec_pkg::madec_pm_req_t      pm_req,
  input  wire logic                    [7:0] flash_rdata,
  output logic                         [7:0] rf_rdata,
  output logic                               ram_we,
  output logic                               ram_re,
  output logic                         [9:0] ram_addr,
  output logic                         [7:0] ram_wdata,
  output logic                               ctrl_we,
  output logic                               ctrl_re,
  output logic                         [7:0] ctrl_addr,
  output logic                         [7:0] ctrl_wdata,
  output madec_pkg::madec_rf_tgt_t           rf_tgt,
  output logic                         [7:0] pm_rdata,
  output logic                               flash_re,
  output logic                               flash_we,
  output logic                        [12:0] flash_addr,
  output logic                         [7:0] flash_wdata,
  output madec_pkg::madec_pm_tgt_t           pm_tgt,
  output logic                               info_en
);

  // =====================================================================
  // bounds
  localparam logic [12:0] RAM_END   = 13'(RAM_BYTES);   // RL5
  localparam logic [16:0] FLASH_END = 17'(FLASH_BYTES); // RL8

  // =====================================================================
  // state
  typedef struct packed {
    logic                      [7:0]  rf_rdata;
    logic                             ram_we;
    logic                             ram_re;
    logic                      [9:0]  ram_addr;
    logic                      [7:0]  ram_wdata;
    logic                             ctrl_we;
    logic                             ctrl_re;
    logic                      [7:0]  ctrl_addr;
    logic                      [7:0]  ctrl_wdata;
    madec_pkg::madec_rf_tgt_t         rf_tgt;
    madec_pkg::madec_rf_tgt_t         rf_tgt_d;
    logic                             rf_rd_d;
    logic                             rf_rd_d2;
    logic                      [7:0]  pm_rdata;
    logic                             flash_re;
    logic                             flash_we;
    logic                      [12:0] flash_addr;
    logic                      [7:0]  flash_wdata;
    madec_pkg::madec_pm_tgt_t         pm_tgt;
    logic                             pm_rd_d;
    logic                             pm_info_d;
    logic                             pm_unimpl_d;
    logic                             pm_rd_d2;
    logic                             pm_info_d2;
    logic                             pm_unimpl_d2;
    logic                      [7:0]  info_q;
    logic                             sel_s1;
    logic                             sel_s2;
    logic                             info_en;
  } madec_state_t;

  madec_state_t st_r;
  madec_state_t st_nxt;
  logic   [7:0] info_rdata;
  logic         rf_in_ram;
  logic         rf_in_ctrl;
  logic         pm_in_flash;
  logic         pm_in_info;

  madec_info_rom u_info (
    .clk   (clk),
    .addr  (pm_req.addr[6:0]),
    .rdata (info_rdata)
  );

  // =====================================================================
  // region compare
  always_comb
  begin
    rf_in_ctrl  = rf_req.addr >= `MADEC_CTRL_BASE;                 // RL2
    rf_in_ram   = {1'b0, rf_req.addr} < RAM_END;                   // RL4
    pm_in_flash = {1'b0, pm_req.addr} < FLASH_END;                 // RL8
    pm_in_info  = st_r.info_en && pm_req.addr >= `MADEC_INFO_LO
                  && pm_req.addr <= `MADEC_INFO_HI;                // RL14 RL17
  end

  // =====================================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    // page select bit passes two sync flops and the info_en flop, then enables overlay
    st_nxt.sel_s1  = page_sel[`MADEC_INFO_EN_BIT];
    st_nxt.sel_s2  = st_r.sel_s1;
    st_nxt.info_en = st_r.sel_s2; // RL13

    // register file: 12-bit address covers exactly 4096 bytes
    st_nxt.ram_we    = 1'b0;
    st_nxt.ram_re    = 1'b0;
    st_nxt.ctrl_we   = 1'b0;
    st_nxt.ctrl_re   = 1'b0;
    st_nxt.ram_addr  = rf_req.addr[9:0];
    st_nxt.ram_wdata = rf_req.wdata;
    st_nxt.ctrl_addr = rf_req.addr[7:0];
    st_nxt.ctrl_wdata = rf_req.wdata;
    if (rf_in_ctrl) // RL1
    begin
      st_nxt.rf_tgt  = madec_pkg::MADEC_RF_CTRL;
      st_nxt.ctrl_we = rf_req.wr; // RL3
      st_nxt.ctrl_re = rf_req.rd;
    end
    else if (rf_in_ram)
    begin
      st_nxt.rf_tgt = madec_pkg::MADEC_RF_RAM;
      st_nxt.ram_we = rf_req.wr;
      st_nxt.ram_re = rf_req.rd;
    end
    else
    begin
      st_nxt.rf_tgt = madec_pkg::MADEC_RF_HOLE; // RL6
    end
    // second stage matches the registered memory's one-cycle latency
    st_nxt.rf_rd_d  = rf_req.rd;
    st_nxt.rf_rd_d2 = st_r.rf_rd_d;
    st_nxt.rf_tgt_d = st_r.rf_tgt;

    // register file read data, three cycles after the request
    if (st_r.rf_rd_d2)
    begin
      unique case (st_r.rf_tgt_d)
        madec_pkg::MADEC_RF_RAM:  st_nxt.rf_rdata = ram_rdata;
        madec_pkg::MADEC_RF_CTRL: st_nxt.rf_rdata = ctrl_rdata;
        madec_pkg::MADEC_RF_HOLE: st_nxt.rf_rdata = `MADEC_RDATA_RST; // RL6
        default:                  st_nxt.rf_rdata = `MADEC_RDATA_RST;
      endcase
    end

    // program memory; no data memory port exists
    st_nxt.flash_re    = 1'b0; // RL12
    st_nxt.flash_we    = 1'b0;
    st_nxt.flash_addr  = pm_req.addr[12:0];
    st_nxt.flash_wdata = pm_req.wdata;
    if (pm_in_info) // RL14
    begin
      st_nxt.pm_tgt = madec_pkg::MADEC_PM_INFO;
      // writes dropped here: overlay never writes anything
    end
    else if (!pm_in_flash) // RL7 RL9 RL17
    begin
      st_nxt.pm_tgt = madec_pkg::MADEC_PM_UNIMPL;
    end
    else
    begin
      st_nxt.flash_re = pm_req.rd;
      st_nxt.flash_we = pm_req.wr;
      if (pm_req.addr < `MADEC_RESET_VEC) // RL10
        st_nxt.pm_tgt = madec_pkg::MADEC_PM_OPTION;
      else if (pm_req.addr < `MADEC_WDT_VEC)
        st_nxt.pm_tgt = madec_pkg::MADEC_PM_RESET_VEC;
      else if (pm_req.addr < `MADEC_ILL_VEC)
        st_nxt.pm_tgt = madec_pkg::MADEC_PM_WDT_VEC;
      else if (pm_req.addr < `MADEC_IRQ_VEC_LO)
        st_nxt.pm_tgt = madec_pkg::MADEC_PM_ILL_VEC;
      else if (pm_req.addr <= `MADEC_IRQ_VEC_HI)
        st_nxt.pm_tgt = madec_pkg::MADEC_PM_IRQ_VEC;
      else if (pm_req.addr < `MADEC_OSC_VEC_LO)
        st_nxt.pm_tgt = madec_pkg::MADEC_PM_RSV_VEC;
      else if (pm_req.addr <= `MADEC_OSC_VEC_HI)
        st_nxt.pm_tgt = madec_pkg::MADEC_PM_OSC_VEC;
      else
        st_nxt.pm_tgt = madec_pkg::MADEC_PM_CODE; // RL11
    end
    st_nxt.pm_rd_d      = pm_req.rd;
    st_nxt.pm_info_d    = pm_in_info;
    st_nxt.pm_unimpl_d  = !pm_in_info && !pm_in_flash;
    st_nxt.pm_rd_d2     = st_r.pm_rd_d;
    st_nxt.pm_info_d2   = st_r.pm_info_d;
    st_nxt.pm_unimpl_d2 = st_r.pm_unimpl_d;
    // info byte held one cycle to line up with flash data
    st_nxt.info_q       = info_rdata;

    if (st_r.pm_rd_d2)
    begin
      if (st_r.pm_info_d2)
        st_nxt.pm_rdata = st_r.info_q; // RL14
      else if (st_r.pm_unimpl_d2)
        st_nxt.pm_rdata = `MADEC_UNIMPL_BYTE; // RL9
      else
        st_nxt.pm_rdata = flash_rdata;
    end

    if (!rst_n)
    begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  // =====================================================================
  // outputs straight from state flops
  assign rf_rdata    = st_r.rf_rdata;
  assign ram_we      = st_r.ram_we;
  assign ram_re      = st_r.ram_re;
  assign ram_addr    = st_r.ram_addr;
  assign ram_wdata   = st_r.ram_wdata;
  assign ctrl_we     = st_r.ctrl_we;
  assign ctrl_re     = st_r.ctrl_re;
  assign ctrl_addr   = st_r.ctrl_addr;
  assign ctrl_wdata  = st_r.ctrl_wdata;
  assign rf_tgt      = st_r.rf_tgt;
  assign pm_rdata    = st_r.pm_rdata;
  assign flash_re    = st_r.flash_re;
  assign flash_we    = st_r.flash_we;
  assign flash_addr  = st_r.flash_addr;
  assign flash_wdata = st_r.flash_wdata;
  assign pm_tgt      = st_r.pm_tgt;
  assign info_en     = st_r.info_en;

endmodule

// file: dv/madec_monitor.sv
// checker: decode strobes, read latency and overlay enable at top ports
// assumes bind from the bench top with the top's parameters
module madec_monitor #(
  parameter int RAM_BYTES   = 1024,
  parameter int FLASH_BYTES = 8192
) (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire madec_pkg::madec_rf_req_t rf_req,
  input wire madec_pkg::madec_pm_req_t pm_req,
  input wire logic               [7:0] page_sel,
  input wire logic               [7:0] ram_rdata,
  input wire logic               [7:0] flash_rdata,
  input wire logic               [7:0] rf_rdata,
  input wire logic               [7:0] pm_rdata,
  input wire logic                     ram_re,
  input wire logic                     ram_we,
  input wire logic               [9:0] ram_addr,
  input wire logic               [7:0] ram_wdata,
  input wire logic                     ctrl_we,
  input wire logic               [7:0] ctrl_addr,
  input wire logic               [7:0] ctrl_wdata,
  input wire logic                     flash_re,
  input wire logic                     flash_we,
  input wire logic              [12:0] flash_addr,
  input wire logic               [7:0] flash_wdata,
  input wire logic                     info_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====
  // decode helpers
  wire ram_hit = rf_req.addr < RAM_BYTES;
  wire hole    = !ram_hit && rf_req.addr < 12'hF00;
  wire ovl     = info_en && pm_req.addr >= 16'hFE00 && pm_req.addr <= 16'hFF7F;
  wire fl_hit  = pm_req.addr < FLASH_BYTES && !ovl;
  sequence flash_ans;
    ##1 flash_re && flash_addr == $past(pm_req.addr[12:0]) ##2 pm_rdata == $past(flash_rdata);
  endsequence
  // ====
  // properties
  ram_rd_a: assert property (
    rf_req.rd && ram_hit |=> ram_re && ram_addr == $past(rf_req.addr[9:0]))
    else $error("ram read strobe wrong");
  ram_data_a: assert property (
    rf_req.rd && ram_hit |-> ##3 rf_rdata == $past(ram_rdata))
    else $error("ram read data wrong");
  ram_wr_a: assert property (
    rf_req.wr && ram_hit |=> ram_we && ram_wdata == $past(rf_req.wdata))
    else $error("ram write wrong");
  flash_wr_a: assert property (
    pm_req.wr && fl_hit |=> flash_we && flash_wdata == $past(pm_req.wdata))
    else $error("flash write wrong");
  hole_quiet_a: assert property (
    rf_req.wr && hole |=> !ram_we && !ctrl_we)
    else $error("hole write reached a target");
  hole_read_a: assert property (
    rf_req.rd && hole |-> ##3 rf_rdata == 8'h00)
    else $error("hole read data wrong");
  ctrl_wr_a: assert property (
    rf_req.wr && rf_req.addr >= 12'hF00 |=> ctrl_we && ctrl_addr == $past(rf_req.addr[7:0])
      && ctrl_wdata == $past(rf_req.wdata))
    else $error("control write wrong");
  flash_rd_a: assert property (pm_req.rd && fl_hit |-> flash_ans)
    else $error("flash read wrong");
  unimpl_rd_a: assert property (
    pm_req.rd && !fl_hit && !ovl |-> ##3 pm_rdata == 8'hFF)
    else $error("unimplemented read not FF");
  pm_nowr_a: assert property (pm_req.wr && !fl_hit |=> !flash_we)
    else $error("refused write reached flash");
  info_lag_a: assert property (info_en == $past(page_sel[7], 3))
    else $error("overlay enable lag wrong");
endmodule

// file: dv/madec_mem_model.sv
// partner: ram, control registers and flash, one cycle read latency
// assumes strobes from the decoder; idle data lines toggle
module madec_mem_model #(
  parameter int RAM_BYTES = 1024
) (
  input  wire logic        clk,
  input  wire logic        ram_we,
  input  wire logic        ram_re,
  input  wire logic [9:0]  ram_addr,
  input  wire logic [7:0]  ram_wdata,
  input  wire logic        ctrl_we,
  input  wire logic        ctrl_re,
  input  wire logic [7:0]  ctrl_addr,
  input  wire logic [7:0]  ctrl_wdata,
  input  wire logic        flash_re,
  input  wire logic [12:0] flash_addr,
  output logic      [7:0]  ram_rdata,
  output logic      [7:0]  ctrl_rdata,
  output logic      [7:0]  flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram_m [RAM_BYTES];
  logic [7:0] ctl_m [256];
  initial
  begin
    foreach (ram_m[i]) ram_m[i] = 8'(i) ^ 8'hA5;
    foreach (ctl_m[i]) ctl_m[i] = 8'(i) ^ 8'h3C;
    {ram_rdata, ctrl_rdata, flash_rdata} = '0;
  end
  always @(posedge clk)
  begin
    if (ram_we) ram_m[ram_addr] <= ram_wdata;
    if (ctrl_we) ctl_m[ctrl_addr] <= ctrl_wdata;
    ram_rdata   <= ram_re ? ram_m[ram_addr] : ~ram_rdata;
    ctrl_rdata  <= ctrl_re ? ctl_m[ctrl_addr] : ~ctrl_rdata;
    flash_rdata <= flash_re ? flash_addr[7:0] ^ flash_addr[12:5] : ~flash_rdata;
  end
endmodule

// file: dv/tb_memory_address_decoder.sv
// bench: corner and random accesses on both channels, overlay on and off
// assumes the memory model and the bound checker
module tb_memory_address_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RB = 512;
  localparam int FB = 4096;
  localparam logic [159:0] PN = {"ANYPART", {13{8'hFF}}};
  localparam logic [11:0] RFC [6] = '{12'h000, 12'(RB-1), 12'(RB), 12'hEFF, 12'hF00, 12'hFFF};
  localparam logic [15:0] PMC [20] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008,
    16'h0037, 16'h0038, 16'h003A, 16'h003D, 16'h003E, 16'(FB-1), 16'(FB), 16'hFE00,
    16'hFE3F, 16'hFE40, 16'hFE53, 16'hFE54, 16'hFF7F, 16'hFF80, 16'hFFFF};
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  madec_pkg::madec_rf_req_t rf_req = '0;
  madec_pkg::madec_pm_req_t pm_req = '0;
  logic [7:0]               page_sel = 8'h00;
  logic [7:0]               ram_rdata, ctrl_rdata, flash_rdata, rf_rdata, pm_rdata;
  logic [7:0]               ram_wdata, ctrl_addr, ctrl_wdata, flash_wdata;
  logic                     ram_we, ram_re, ctrl_we, ctrl_re, flash_re, flash_we, info_en;
  logic [9:0]               ram_addr;
  logic [12:0]              flash_addr;
  madec_pkg::madec_rf_tgt_t rf_tgt;
  madec_pkg::madec_pm_tgt_t pm_tgt;
  logic [7:0]               ram_ref [RB];
  logic [7:0]               ctl_ref [256];
  logic [23:0]              e_rf = '0, e_pm = '0;
  logic [2:0]               v_rf = '0, v_pm = '0;
  logic [7:0]               c_erf = '0, c_epm = '0;
  logic [3:0]               c_trf = '0, c_tpm = '0, t_rf = '0, t_pm = '0;
  logic                     c_vrf = 1'b0, c_vpm = 1'b0, ie = 1'b0;
  logic [11:0]              ra;
  logic [15:0]              pa;
  logic [1:0]               po;
  int                       error_cnt = 0, n_checks = 0, cyc = 0;

  madec_top #(.RAM_BYTES(RB), .FLASH_BYTES(FB)) u_dut (
    .clk(clk), .rst_n(rst_n), .rf_req(rf_req), .ram_rdata(ram_rdata),
    .ctrl_rdata(ctrl_rdata), .page_sel(page_sel), .pm_req(pm_req), .flash_rdata(flash_rdata),
    .rf_rdata(rf_rdata), .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ctrl_we(ctrl_we), .ctrl_re(ctrl_re), .ctrl_addr(ctrl_addr),
    .ctrl_wdata(ctrl_wdata), .rf_tgt(rf_tgt), .pm_rdata(pm_rdata), .flash_re(flash_re),
    .flash_we(flash_we), .flash_addr(flash_addr), .flash_wdata(flash_wdata), .pm_tgt(pm_tgt),
    .info_en(info_en)
  );
  madec_mem_model #(.RAM_BYTES(RB)) u_mem (
    .clk(clk), .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ctrl_we(ctrl_we), .ctrl_re(ctrl_re), .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata),
    .flash_re(flash_re), .flash_addr(flash_addr), .ram_rdata(ram_rdata),
    .ctrl_rdata(ctrl_rdata), .flash_rdata(flash_rdata)
  );
  always #2.5 clk = ~clk;
  // ====
  // expectations and compares
  function automatic logic [7:0] pm_exp_d(input logic [15:0] a, input logic en);
    if (en && a >= 16'hFE00 && a <= 16'hFF7F)
      return (a[6:0] >= 7'h40 && a[6:0] <= 7'h53) ? PN[159 - 8 * (a[6:0] - 7'h40) -: 8] : 8'hFF;
    if (a >= FB) return 8'hFF;
    return a[7:0] ^ a[12:5];
  endfunction
  function automatic logic [3:0] pm_exp_t(input logic [15:0] a, input logic en);
    if (en && a >= 16'hFE00 && a <= 16'hFF7F) return 4'h9;
    if (a >= FB) return 4'h8;
    return a < 16'h8 ? 4'(a[2:1]) : a < 16'h38 ? 4'h4 : a < 16'h3A ? 4'h5 : a < 16'h3E ? 4'h6 : 4'h7;
  endfunction
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_t(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ro and po: bit 0 read, bit 1 write
  task automatic drive(input logic [1:0] ro, input logic [11:0] a, input logic [1:0] pop,
                       input logic [15:0] p, input logic [7:0] wd);
    @(posedge clk);
    rf_req <= {ro[0], ro[1], a, wd};
    pm_req <= {pop[0], pop[1], p, wd};
    c_vrf = ro[0];
    c_vpm = pop[0];
    c_erf = a < RB ? ram_ref[a] : a < 12'hF00 ? 8'h00 : ctl_ref[a[7:0]];
    c_trf = a < RB ? 4'h0 : a < 12'hF00 ? 4'h1 : 4'h2;
    c_epm = pm_exp_d(p, ie);
    c_tpm = pm_exp_t(p, ie);
    if (ro[1] && a < RB) ram_ref[a] = wd;
    if (ro[1] && a >= 12'hF00) ctl_ref[a[7:0]] = wd;
  endtask
  // ====
  // response pipeline, target one cycle and data three cycles after sampling
  always @(negedge clk)
  begin
    if (v_rf[0]) chk_t("rf_tgt", t_rf, 4'(rf_tgt));
    if (v_pm[0]) chk_t("pm_tgt", t_pm, 4'(pm_tgt));
    if (v_rf[2]) chk8("rf_rdata", e_rf[23:16], rf_rdata);
    if (v_pm[2]) chk8("pm_rdata", e_pm[23:16], pm_rdata);
    e_rf = {e_rf[15:0], c_erf};
    e_pm = {e_pm[15:0], c_epm};
    v_rf = {v_rf[1:0], c_vrf};
    v_pm = {v_pm[1:0], c_vpm};
    t_rf = c_trf;
    t_pm = c_tpm;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  // ====
  // main sequence
  initial
  begin
    void'($urandom(32'hBF8C));
    foreach (ram_ref[i]) ram_ref[i] = 8'(i) ^ 8'hA5;
    foreach (ctl_ref[i]) ctl_ref[i] = 8'(i) ^ 8'h3C;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      ie = k[0];
      drive(0, 0, 0, 0, 0);
      page_sel <= {k[0], k[0] ? 7'h00 : 7'h7F};
      repeat (4) drive(0, 0, 0, 0, 0);
      @(negedge clk);
      chk8("info_en", {7'h00, ie}, {7'h00, info_en});
      foreach (PMC[i]) drive(2, RFC[i % 6], 1, PMC[i], 8'($urandom));
      foreach (PMC[i]) drive(1, RFC[i % 6], PMC[i] >= FB ? 2 : 1, PMC[i], 8'($urandom));
      repeat (300)
      begin
        ra = ($urandom % 2) ? 12'($urandom) : RFC[$urandom % 6];
        case ($urandom % 4)
          0: pa = 16'($urandom % 80);
          1: pa = 16'($urandom % FB);
          2: pa = 16'hFE00 + 16'($urandom % 512);
          default: pa = 16'($urandom);
        endcase
        po = 2'($urandom % 3);
        drive(2'($urandom % 3), ra, po, pa, 8'($urandom));
      end
    end
    repeat (4) drive(0, 0, 0, 0, 0);
    wrap_up();
  end
endmodule

bind madec_top madec_monitor #(.RAM_BYTES(RAM_BYTES), .FLASH_BYTES(FLASH_BYTES)) u_mon (
  .clk(clk), .rst_n(rst_n), .rf_req(rf_req), .pm_req(pm_req), .page_sel(page_sel),
  .ram_rdata(ram_rdata), .flash_rdata(flash_rdata), .rf_rdata(rf_rdata), .pm_rdata(pm_rdata),
  .ram_re(ram_re), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
  .ctrl_we(ctrl_we), .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .flash_re(flash_re),
  .flash_we(flash_we), .flash_addr(flash_addr), .flash_wdata(flash_wdata), .info_en(info_en)
);
